// ==== src/dbf_pkg.sv ====
// dbf_pkg: constants shared by the dual-bank flash host controller.
// assumes a 100 MHz system clock and a 70 ns speed grade part.
package dbf_pkg;
    // ---------------------------------------------------------------
    // clock and pin timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACC_NS        = 70;
    localparam int WE_PULSE_NS   = 35;
    localparam int RST_PULSE_NS  = 500;
    localparam int CNT_W         = 8;
    localparam logic [CNT_W-1:0] ACC_CYC =
        CNT_W'((ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WE_CYC  =
        CNT_W'((WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RST_CYC =
        CNT_W'((RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ---------------------------------------------------------------
    // flash geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W     = 21;
    localparam int DATA_W     = 16;
    localparam int BANK_W     = 2;
    localparam int BANK_LSB   = 19;

    // ---------------------------------------------------------------
    // register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_ADDR   = 5'h04;
    localparam logic [4:0] OFS_WDATA  = 5'h08;
    localparam logic [4:0] OFS_CMD    = 5'h0C;
    localparam logic [4:0] OFS_RDATA  = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;

    // CTRL fields
    localparam int CTRL_BYTE    = 0;
    localparam int CTRL_HOLDRST = 1;
    localparam int CTRL_PROTACC = 2;
    localparam int CTRL_ESUSP   = 3;
    localparam int CTRL_SECENT  = 4;
    localparam int CTRL_W       = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h04;

    // CMD fields
    localparam int CMD_GO     = 0;
    localparam int CMD_WRITE  = 1;
    localparam int CMD_SECURE = 2;
    localparam int CMD_OPSTART = 3;

    // STATUS fields
    localparam int ST_CYCBUSY  = 0;
    localparam int ST_READY    = 1;
    localparam int ST_OPACTIVE = 2;
    localparam int ST_REFUSED  = 3;
    localparam int ST_OPBANK   = 4;

    typedef enum logic [2:0] {
        SEQ_IDLE    = 3'b000,
        SEQ_SETUP   = 3'b001,
        SEQ_STROBE  = 3'b010,
        SEQ_RECOVER = 3'b011,
        SEQ_RESET   = 3'b100
    } dbf_seq_t;
endpackage : dbf_pkg

// ==== src/dbf_host.sv ====
// dbf_host: host controller for a dual-bank parallel NOR flash.
// assumes flash pin inputs synchronous to sys_clk; software on Avalon-MM.
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dbf_host
    import dbf_pkg::*;
(
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    input  wire logic [4:0]                 avsAddress,
    input  wire logic                       avsRead,
    input  wire logic                       avsWrite,
    input  wire logic [31:0]                avsWritedata,
    input  wire logic [3:0]                 avsByteenable,
    output var  logic [31:0]                avsReaddata,
    output var  logic                       avsWaitrequest,
    output var  logic [dbf_pkg::ADDR_W-1:0] word_address_lines,
    input  wire logic [14:0]                data_lines_low_in,
    output var  logic [14:0]                data_lines_low_out,
    output var  logic [14:0]                data_lines_low_oe,
    input  wire logic                       top_data_or_byte_addr_in,
    output var  logic                       top_data_or_byte_addr_out,
    output var  logic                       top_data_or_byte_addr_oe,
    output var  logic                       flashCeN,
    output var  logic                       flashOeN,
    output var  logic                       flashWeN,
    output var  logic                       flashResetN,
    output var  logic                       flashByteN,
    output var  logic                       protect_accel_pin,
    input  wire logic                       ready_busy_n
);
    import dbf_pkg::*;

    // ---------------------------------------------------------------
    // registers and bus decode
    // ---------------------------------------------------------------
    logic [CTRL_W-1:0]    ctrl;
    logic [ADDR_W:0]      addrReg;
    logic [DATA_W-1:0]    wdataReg;
    logic [DATA_W-1:0]    rdataReg;
    logic                 refused;
    logic                 opActive;
    logic [BANK_W-1:0]    opBank;
    logic                 readyPrev;
    dbf_seq_t             seq;
    logic [CNT_W-1:0]     cnt;
    logic                 cycWrite;
    logic                 cycSecure;
    logic                 cycOpStart;

    wire wrAccept   = avsWrite & ~avsWaitrequest & avsByteenable[0];
    wire wrCtrl     = wrAccept & (avsAddress == OFS_CTRL);
    wire wrAddr     = wrAccept & (avsAddress == OFS_ADDR);
    wire wrWdata    = wrAccept & (avsAddress == OFS_WDATA);
    wire wrCmd      = wrAccept & (avsAddress == OFS_CMD);
    wire wrStatus   = wrAccept & (avsAddress == OFS_STATUS);
    wire goReq      = wrCmd & avsWritedata[CMD_GO];
    wire reqWrite   = avsWritedata[CMD_WRITE];
    wire reqSecure  = avsWritedata[CMD_SECURE];
    wire [BANK_W-1:0] reqBank = addrReg[ADDR_W:BANK_LSB+1];
    // a third bank cannot be written while another runs its embedded op, unless CTRL_ESUSP is set
    wire badBank    = reqWrite & opActive & ~ctrl[CTRL_ESUSP]
                      & (reqBank != opBank);
    // secure reads under suspend are only legal inside entry/exit bracket
    wire badSecure  = reqSecure & ctrl[CTRL_ESUSP] & ~ctrl[CTRL_SECENT];
    wire canLaunch  = (seq == SEQ_IDLE) & ~ctrl[CTRL_HOLDRST];
    wire launch     = goReq & canLaunch & ~badBank & ~badSecure;
    wire refuseEvt  = goReq & ~launch;
    wire readyRose  = ready_busy_n & ~readyPrev;
    wire byteMode   = ctrl[CTRL_BYTE];
    wire [DATA_W-1:0] capData = byteMode ? {8'h00, data_lines_low_in[7:0]}
                                         : {top_data_or_byte_addr_in, data_lines_low_in};
    wire [31:0] statusWord = {26'h000_0000, opBank, refused, opActive,
                              ready_busy_n, (seq != SEQ_IDLE)};
    wire [31:0] rdMux =
        (avsAddress == OFS_CTRL)   ? {27'h000_0000, ctrl} :
        (avsAddress == OFS_ADDR)   ? {10'h000, addrReg} :
        (avsAddress == OFS_WDATA)  ? {16'h0000, wdataReg} :
        (avsAddress == OFS_RDATA)  ? {16'h0000, rdataReg} :
        (avsAddress == OFS_STATUS) ? statusWord : 32'h0000_0000;

    // ---------------------------------------------------------------
    // Avalon slave: one wait cycle, then the answer
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            avsWaitrequest <= 1'b1;
            avsReaddata    <= 32'h0000_0000;
        end else begin
            avsWaitrequest <= ~((avsRead | avsWrite) & avsWaitrequest);
            if (avsRead & avsWaitrequest)
                avsReaddata <= rdMux;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl     <= CTRL_RESET;
            addrReg  <= '0;
            wdataReg <= '0;
        end else begin
            if (wrCtrl)
                ctrl <= avsWritedata[CTRL_W-1:0];
            if (wrAddr)
                addrReg <= avsWritedata[ADDR_W:0];
            if (wrWdata)
                wdataReg <= avsWritedata[DATA_W-1:0];
        end
    end

    // refusal flag: a new refusal beats a clear in the same cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            refused <= 1'b0;
        else if (refuseEvt)
            refused <= 1'b1;
        else if (wrStatus & avsWritedata[ST_REFUSED])
            refused <= 1'b0;
    end

    // ---------------------------------------------------------------
    // embedded operation tracking, ended by the ready/busy line rising or by a flash reset pulse
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            opActive  <= 1'b0;
            opBank    <= '0;
            readyPrev <= 1'b1;
        end else begin
            readyPrev <= ready_busy_n;
            if (launch & reqWrite & avsWritedata[CMD_OPSTART]) begin
                opActive <= 1'b1;
                opBank   <= reqBank;
            end else if (readyRose | (seq == SEQ_RESET)) begin
                opActive <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // pin sequencer; power-up starts with a reset pulse
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            seq        <= SEQ_RESET;
            cnt        <= RST_CYC - 8'h01;
            cycWrite   <= 1'b0;
            cycSecure  <= 1'b0;
            cycOpStart <= 1'b0;
            rdataReg   <= '0;
        end else begin
            unique case (seq)
                SEQ_IDLE: begin
                    if (ctrl[CTRL_HOLDRST]) begin
                        seq <= SEQ_RESET;
                        cnt <= RST_CYC - 8'h01;
                    end else if (launch) begin
                        seq        <= SEQ_SETUP;
                        cycWrite   <= reqWrite;
                        cycSecure  <= reqSecure;
                        cycOpStart <= avsWritedata[CMD_OPSTART];
                    end
                end
                SEQ_SETUP: begin
                    seq <= SEQ_STROBE;
                    cnt <= (cycWrite ? WE_CYC : ACC_CYC) - 8'h01;
                end
                SEQ_STROBE: begin
                    if (cnt == '0) begin
                        seq <= SEQ_RECOVER;
                        if (!cycWrite)
                            rdataReg <= capData;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                SEQ_RECOVER: seq <= SEQ_IDLE;
                SEQ_RESET: begin
                    if (cnt != '0)
                        cnt <= cnt - 8'h01;
                    else if (!ctrl[CTRL_HOLDRST])
                        seq <= SEQ_IDLE;
                end
                default: seq <= SEQ_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // registered pin drive
    // ---------------------------------------------------------------
    wire strobeNext = (seq == SEQ_SETUP) | ((seq == SEQ_STROBE) & (cnt != '0));
    wire busCycNext = (seq == SEQ_IDLE) ? launch
                                        : ((seq == SEQ_SETUP) | (seq == SEQ_STROBE));
    wire isWrNext   = (seq == SEQ_IDLE) ? reqWrite : cycWrite;
    wire resetNext  = (seq == SEQ_RESET) & ~((cnt == '0) & ~ctrl[CTRL_HOLDRST]);
    wire enterRst   = (seq == SEQ_IDLE) & ctrl[CTRL_HOLDRST];

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flashCeN    <= 1'b1;
            flashOeN    <= 1'b1;
            flashWeN    <= 1'b1;
            flashResetN <= 1'b0;
        end else begin
            flashCeN    <= ~busCycNext;
            flashOeN    <= ~(strobeNext & ~cycWrite);
            flashWeN    <= ~(strobeNext & cycWrite);
            flashResetN <= ~(resetNext | enterRst);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            word_address_lines        <= '0;
            data_lines_low_out        <= '0;
            data_lines_low_oe         <= '0;
            top_data_or_byte_addr_out <= 1'b0;
            top_data_or_byte_addr_oe  <= 1'b0;
            flashByteN                <= 1'b1;
            protect_accel_pin         <= 1'b1;
        end else begin
            flashByteN        <= ~byteMode;
            protect_accel_pin <= ctrl[CTRL_PROTACC];
            if (launch)
                word_address_lines <= addrReg[ADDR_W:1];
            // upper lanes stay off in byte mode: the part floats them
            data_lines_low_oe  <= (busCycNext & isWrNext)
                                  ? (byteMode ? 15'h00FF : 15'h7FFF) : 15'h0000;
            if (launch)
                data_lines_low_out <= wdataReg[14:0];
            if (launch)
                top_data_or_byte_addr_out <= byteMode ? addrReg[0] : wdataReg[15];
            top_data_or_byte_addr_oe <= busCycNext & (byteMode | isWrNext);
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_read_strobes;
        @(posedge sys_clk) disable iff (!resetn)
        !flashOeN |-> (!flashCeN && flashWeN);
    endproperty
    a_read_strobes: assert property (p_read_strobes) else $error("read without ce or with we");

    property p_write_strobes;
        @(posedge sys_clk) disable iff (!resetn)
        !flashWeN |-> (!flashCeN && flashOeN);
    endproperty
    a_write_strobes: assert property (p_write_strobes) else $error("write without ce or with oe");

    property p_we_pulse;
        @(posedge sys_clk) disable iff (!resetn)
        $fell(flashWeN) |-> !flashWeN[*4] ##1 flashWeN ##1 flashCeN;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write pulse width wrong");

    property p_addr_stable;
        @(posedge sys_clk) disable iff (!resetn)
        (!flashCeN && !$past(flashCeN)) |-> $stable(word_address_lines);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in cycle");

    property p_byte_lsb;
        @(posedge sys_clk) disable iff (!resetn)
        (!flashCeN && !flashByteN) |->
            (top_data_or_byte_addr_oe && data_lines_low_oe[14:8] == 7'h00);
    endproperty
    a_byte_lsb: assert property (p_byte_lsb) else $error("byte mode pin use wrong");

    property p_width_sel;
        @(posedge sys_clk) disable iff (!resetn)
        (seq == SEQ_SETUP) |-> (flashByteN == !ctrl[CTRL_BYTE]);
    endproperty
    a_width_sel: assert property (p_width_sel) else $error("width select mismatch");

    property p_reset_quiet;
        @(posedge sys_clk) disable iff (!resetn)
        $fell(flashResetN) |-> (!flashResetN && flashCeN)[*8];
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("flash reset too short or busy");

    property p_two_banks;
        @(posedge sys_clk) disable iff (!resetn)
        (seq == SEQ_SETUP && cycWrite && opActive && !cycOpStart && !ctrl[CTRL_ESUSP])
            |-> (word_address_lines[ADDR_W-1:BANK_LSB] == opBank);
    endproperty
    a_two_banks: assert property (p_two_banks) else $error("write reached a third bank");

    property p_secure_entry;
        @(posedge sys_clk) disable iff (!resetn)
        (seq == SEQ_SETUP && cycSecure && ctrl[CTRL_ESUSP]) |-> ctrl[CTRL_SECENT];
    endproperty
    a_secure_entry: assert property (p_secure_entry) else $error("secure access outside entry");
endmodule : dbf_host
`default_nettype wire

// ==== bench/dbf_flash_model.sv ====
// dbf_flash_model: behavioural dual-bank parallel flash for the host bench.
// assumes the bench resolves the shared data pins and feeds the wire level back in.
`timescale 1ns/1ps
`default_nettype none
module dbf_flash_model #(
    parameter int         BUSY_NS   = 5000,
    parameter int         ACC_NS    = 60,
    parameter logic [1:0] PROT_BANK = 2'h3
) (
    input  wire logic        ceN,
    input  wire logic        oeN,
    input  wire logic        weN,
    input  wire logic        resetN,
    input  wire logic        byteN,
    input  wire logic        supplyLow,
    input  wire logic [20:0] addr,
    input  wire logic [14:0] dqIn,
    input  wire logic        topIn,
    output wire logic [14:0] dqOut,
    output wire logic [14:0] dqOe,
    output wire logic        topOut,
    output wire logic        topOe,
    output wire logic        rdyBusyN
);
    // ---------------------------------------------------------------
    // array and status
    // ---------------------------------------------------------------
    logic [15:0] mem [int];
    logic [15:0] rdVal;
    logic [15:0] lastProg = 16'h0000;
    logic        busy     = 1'b0;
    logic        tog      = 1'b0;
    logic [1:0]  busyBank = 2'h0;
    int          wrCnt    = 0;
    wire  [1:0]  bank     = addr[20:19];
    wire         selRd    = !ceN && !oeN && weN && resetN;
    wire  [7:0]  byteVal  = topIn ? rdVal[15:8] : rdVal[7:0];
    // the unused byte lane programs as all ones so it leaves the cell alone
    wire  [15:0] wd = byteN ? {topIn, dqIn} :
                      (topIn ? {dqIn[7:0], 8'hFF} : {8'hFF, dqIn[7:0]});

    always @(addr, busy, busyBank, tog, lastProg, wrCnt) begin
        if (busy && bank == busyBank)
            rdVal = {8'h00, ~lastProg[7], tog, 3'b000, tog, 2'b00};
        else
            rdVal = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hFFFF;
    end

    assign #ACC_NS dqOut = byteN ? rdVal[14:0] : {7'h00, byteVal};
    assign dqOe     = selRd ? (byteN ? 15'h7FFF : 15'h00FF) : 15'h0000;
    assign topOut   = rdVal[15];
    assign topOe    = selRd && byteN;
    assign rdyBusyN = !busy;

    // ---------------------------------------------------------------
    // program and completion
    // ---------------------------------------------------------------
    // one embedded op at a time, so a second bank never starts while busy
    always @(posedge weN) begin
        if (!ceN && oeN && resetN && !supplyLow && !busy && bank != PROT_BANK) begin
            mem[int'(addr)] = rdVal & wd;
            lastProg = wd;
            busyBank = bank;
            busy = 1'b1;
            wrCnt++;
        end
    end
    always @(posedge busy) begin
        // lands off the clock edge so the host never races the ready line
        #(BUSY_NS + 3);
        busy = 1'b0;
    end
    always @(negedge resetN) busy = 1'b0;
    always @(negedge oeN) if (busy && !ceN && bank == busyBank) tog = ~tog;
endmodule : dbf_flash_model
`default_nettype wire

// ==== bench/test_dbf_host.sv ====
// test_dbf_host: self-checking bench for the dual-bank flash host controller.
// assumes dbf_pkg offsets and the behavioural flash model beside it.
`timescale 1ns/1ps
`default_nettype none
module test_dbf_host;
    import dbf_pkg::*;
    logic        sys_clk;
    logic        resetn;
    logic [4:0]  avsAddress;
    logic        avsRead;
    logic        avsWrite;
    logic [31:0] avsWritedata;
    logic [3:0]  avsByteenable;
    logic        supplyLow;
    logic [31:0] q;
    logic [14:0] lastDq  = 15'h0000;
    logic        lastTop = 1'b0;
    int          mismatches = 0;
    int          compares   = 0;
    wire logic [31:0]       avsReaddata;
    wire logic [ADDR_W-1:0] addrLines;
    wire logic [14:0]       hOut, hOe, mOut, mOe, dqBus;
    wire logic avsWaitrequest, hTop, hTopOe, mTop, mTopOe, topBus;
    wire logic ceN, oeN, weN, rstN, byteN, protPin, rdyN;

    // released lines flip every cycle so a stale value never reads back
    assign dqBus  = (hOe & hOut) | (~hOe & mOe & mOut) | (~hOe & ~mOe & ~lastDq);
    assign topBus = hTopOe ? hTop : (mTopOe ? mTop : ~lastTop);
    always @(posedge sys_clk) lastDq <= dqBus;
    always @(posedge sys_clk) lastTop <= topBus;

    dbf_host DUT (.sys_clk(sys_clk), .resetn(resetn), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .word_address_lines(addrLines),
        .data_lines_low_in(dqBus), .data_lines_low_out(hOut), .data_lines_low_oe(hOe),
        .top_data_or_byte_addr_in(topBus), .top_data_or_byte_addr_out(hTop),
        .top_data_or_byte_addr_oe(hTopOe), .flashCeN(ceN), .flashOeN(oeN),
        .flashWeN(weN), .flashResetN(rstN), .flashByteN(byteN),
        .protect_accel_pin(protPin), .ready_busy_n(rdyN));
    dbf_flash_model flash (.ceN(ceN), .oeN(oeN), .weN(weN), .resetN(rstN),
        .byteN(byteN), .supplyLow(supplyLow), .addr(addrLines), .dqIn(dqBus),
        .topIn(topBus), .dqOut(mOut), .dqOe(mOe), .topOut(mTop), .topOe(mTopOe),
        .rdyBusyN(rdyN));

    // ---------------------------------------------------------------
    // access tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avsAddress   <= a;
        avsWritedata <= d;
        avsWrite     <= wr;
        avsRead      <= !wr;
        // no local limit: only the watchdog ends a hung wait
        do begin
            @(posedge sys_clk);
        end while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(q, exp);
    endtask : rdc
    task automatic flashOp(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
        bus(1'b1, OFS_ADDR, a);
        bus(1'b1, OFS_WDATA, d);
        bus(1'b1, OFS_CMD, c);
        do begin
            bus(1'b0, OFS_STATUS, 32'h0000_0000);
        end while (q[0] !== 1'b0);
    endtask : flashOp
    task automatic flashRd(input logic [31:0] a, input logic [31:0] exp);
        flashOp(a, 32'h0000_0000, 32'h0000_0001);
        rdc(OFS_RDATA, exp);
    endtask : flashRd
    task automatic final_report;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // ---------------------------------------------------------------
    // clock, watchdog and tests
    // ---------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #200_000;
        mismatches++;
        final_report();
    end
    initial begin
        resetn = 1'b0;
        avsAddress = 5'h00;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWritedata = 32'h0000_0000;
        avsByteenable = 4'hF;
        supplyLow = 1'b0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        check({31'h0, rstN}, 32'h0000_0000);
        rdc(OFS_CTRL, 32'h0000_0004);
        check({31'h0, protPin}, 32'h0000_0001);
        rdc(5'h18, 32'h0000_0000);
        repeat (50) @(posedge sys_clk);
        check({31'h0, rstN}, 32'h0000_0001);
        flashRd(32'h0000_0200, 32'h0000_FFFF);
        flashOp(32'h0000_0020, 32'h0000_1234, 32'h0000_000B);
        rdc(OFS_STATUS, 32'h0000_0004);
        flashRd(32'h0000_0020, 32'h0000_00C4);
        flashRd(32'h0000_0020, 32'h0000_0080);
        flashRd(32'h0010_0000, 32'h0000_FFFF);
        flashOp(32'h0020_0000, 32'h0000_5555, 32'h0000_0003);
        rdc(OFS_STATUS, 32'h0000_000C);
        bus(1'b1, OFS_STATUS, 32'h0000_0008);
        flashOp(32'h0000_0040, 32'h0000_0000, 32'h0000_0003);
        rdc(OFS_STATUS, 32'h0000_0004);
        bus(1'b1, OFS_CTRL, 32'h0000_000C);
        flashOp(32'h0020_0000, 32'h0000_5555, 32'h0000_0003);
        rdc(OFS_STATUS, 32'h0000_0004);
        bus(1'b1, OFS_CTRL, 32'h0000_0004);
        do begin
            bus(1'b0, OFS_STATUS, 32'h0000_0000);
        end while (q[1] !== 1'b1);
        rdc(OFS_STATUS, 32'h0000_0002);
        flashRd(32'h0000_0020, 32'h0000_1234);
        flashOp(32'h0030_0000, 32'h0000_0000, 32'h0000_0003);
        flashRd(32'h0030_0000, 32'h0000_FFFF);
        supplyLow <= 1'b1;
        flashOp(32'h0000_0040, 32'h0000_0000, 32'h0000_0003);
        supplyLow <= 1'b0;
        flashRd(32'h0000_0040, 32'h0000_FFFF);
        bus(1'b1, OFS_CTRL, 32'h0000_000C);
        flashOp(32'h0000_0020, 32'h0000_0000, 32'h0000_0005);
        rdc(OFS_STATUS, 32'h0000_000A);
        bus(1'b1, OFS_STATUS, 32'h0000_0008);
        bus(1'b1, OFS_CTRL, 32'h0000_001C);
        flashOp(32'h0000_0020, 32'h0000_0000, 32'h0000_0005);
        rdc(OFS_RDATA, 32'h0000_1234);
        rdc(OFS_STATUS, 32'h0000_0002);
        bus(1'b1, OFS_CTRL, 32'h0000_0005);
        @(posedge sys_clk);
        check({31'h0, byteN}, 32'h0000_0000);
        flashRd(32'h0000_0021, 32'h0000_0012);
        flashRd(32'h0000_0020, 32'h0000_0034);
        bus(1'b1, OFS_CTRL, 32'h0000_0006);
        @(posedge sys_clk);
        check({31'h0, rstN}, 32'h0000_0000);
        check({31'h0, byteN}, 32'h0000_0001);
        bus(1'b1, OFS_CTRL, 32'h0000_0004);
        final_report();
    end
endmodule : test_dbf_host
`default_nettype wire
